// *** cfgld_pkg.sv ***
// Constants, field positions and types shared by the configuration loader
package cfgld_pkg;
	localparam int PORTS = 3;
	localparam int ADDR_W = 8;
	localparam int WORD_W = 16;
	// ----------------------------------------------------------------
	// Word addresses in the serial memory (byte addressed)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_SIG = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_VEN = 8'h02;
	localparam logic [ADDR_W-1:0] ADDR_DEV = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CAPA = 8'h06;
	localparam logic [ADDR_W-1:0] ADDR_CAPB = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
	// Arbitrary value, not tied to any real part
	localparam logic [WORD_W-1:0] SIG_DEFAULT = 16'hC0DE;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic [31:0] IMG_RST = 32'h0000_0000;
	// ----------------------------------------------------------------
	// Source bit positions, first and second capability words
	// ----------------------------------------------------------------
	localparam int A_VC = 0, A_L0S = 1, A_L1 = 4, A_NOEGR = 8, A_NOTAG = 9;
	localparam int A_SAF = 10, A_CUT = 11, A_ARB = 13, A_CRD = 14, A_INTA = 15;
	localparam int B_MPS = 0, B_ASPM = 2, B_RBER = 4, B_MSIDIS = 5, B_CPPDIS = 6;
	localparam int B_PMDIS = 7, B_PPNP = 8, B_LBN = 9, B_ORDFRZ = 10, B_TXSOF = 11;
	localparam int B_SDN = 12, B_PMDS = 13, B_LTR = 14, B_BND4K = 15;
	localparam int W_LAT = 3, W_CUT = 2, W_MPS = 2, W_ASPM = 2;
	// ----------------------------------------------------------------
	// Destination bit positions in the per-port register images
	// ----------------------------------------------------------------
	localparam int D144_VC = 0, D3C_INTA = 8, D70_PMDIS = 13, D70_MSIDIS = 14;
	localparam int D74_SAF = 0, D74_CUT = 1, D74_ARB = 3, D74_CRD = 4;
	localparam int D74_NOEGR = 5, D74_NOTAG = 6, D74_CPPDIS = 15;
	localparam int D8C_TXSOF = 0, D8C_PMDS = 1, D8C_BND4K = 3, D8C_PPNP = 5;
	localparam int D8C_ORDFRZ = 6, DC4_MPS = 0, DC4_RBER = 15, DE4_LTR = 12;
	localparam int DCC_ASPM = 10, DCC_L0S = 12, DCC_L1 = 15, DCC_SDN = 19;
	localparam int DCC_LBN = 21;
	typedef logic [PORTS-1:0][31:0] cfgld_img_type;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_SIG = 4'h1,
		ST_VEN = 4'h3,
		ST_DEV = 4'h2,
		ST_CAPA = 4'h6,
		ST_CAPB = 4'h7,
		ST_APPLY = 4'h5,
		ST_DONE = 4'h4,
		ST_FAIL = 4'h9
	} cfgld_state_type;
endpackage

// *** cfgld_word_if.sv ***
// Word request and answer between the sequencer and the memory fetcher
`timescale 1ns/1ns
interface cfgld_word_if;
	logic req;
	logic [7:0] addr;
	logic [15:0] word;
	logic valid;
	modport ctrl (output req, output addr, input word, input valid);
	modport fetch (input req, input addr, output word, output valid);
endinterface

// *** cfgld_fetch.sv ***
// Single-word fetcher facing the external memory reader
`timescale 1ns/1ns
module cfgld_fetch import cfgld_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	cfgld_word_if.fetch wif,
	output logic rom_rd_o,
	output logic [ADDR_W-1:0] rom_addr_o,
	input wire logic [WORD_W-1:0] rom_data_i,
	input wire logic rom_ack_i
);
	wire take_w = rom_rd_o && rom_ack_i;
	wire start_w = !rom_rd_o && wif.req;

	// Read held high until acknowledged; the reader sets the pace
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rom_rd_o <= 1'b0;
			rom_addr_o <= ADDR_RST;
			wif.word <= WORD_RST;
			wif.valid <= 1'b0;
		end else if (ce_i) begin
			wif.valid <= take_w;
			if (take_w) begin
				rom_rd_o <= 1'b0;
				wif.word <= rom_data_i;
			end else if (start_w) begin
				rom_rd_o <= 1'b1;
				rom_addr_o <= wif.addr;
			end
		end
	end
endmodule // cfgld_fetch

// *** cfgld_scatter.sv ***
// Scatters the two capability words into per-port register images
`timescale 1ns/1ns
module cfgld_scatter import cfgld_pkg::*; (
	input wire logic [WORD_W-1:0] word_a_i,
	input wire logic [WORD_W-1:0] word_b_i,
	output cfgld_img_type img_3c_o,
	output cfgld_img_type img_70_o,
	output cfgld_img_type img_74_o,
	output cfgld_img_type img_8c_o,
	output cfgld_img_type img_c4_o,
	output cfgld_img_type img_cc_o,
	output cfgld_img_type img_e4_o,
	output cfgld_img_type img_144_o
);
	function automatic logic [31:0] f_74(input logic [15:0] a, input logic [15:0] b);
		logic [31:0] r;
		r = IMG_RST;
		r[D74_NOEGR] = a[A_NOEGR];
		r[D74_NOTAG] = a[A_NOTAG];
		r[D74_SAF] = a[A_SAF];
		r[D74_CUT +: W_CUT] = a[A_CUT +: W_CUT];
		r[D74_ARB] = a[A_ARB];
		r[D74_CRD] = a[A_CRD];
		r[D74_CPPDIS] = b[B_CPPDIS];
		return r;
	endfunction

	function automatic logic [31:0] f_cc(input logic [15:0] a, input logic [15:0] b,
			input logic dn);
		logic [31:0] r;
		r = IMG_RST;
		r[DCC_L0S +: W_LAT] = a[A_L0S +: W_LAT];
		r[DCC_L1 +: W_LAT] = a[A_L1 +: W_LAT];
		r[DCC_ASPM +: W_ASPM] = b[B_ASPM +: W_ASPM];
		r[DCC_LBN] = b[B_LBN] & dn;
		r[DCC_SDN] = b[B_SDN];
		return r;
	endfunction

	function automatic logic [31:0] f_8c(input logic [15:0] b);
		logic [31:0] r;
		r = IMG_RST;
		r[D8C_PPNP] = b[B_PPNP];
		r[D8C_ORDFRZ] = b[B_ORDFRZ];
		r[D8C_TXSOF] = b[B_TXSOF];
		r[D8C_PMDS] = b[B_PMDS];
		r[D8C_BND4K] = b[B_BND4K];
		return r;
	endfunction

	function automatic logic [31:0] f_bit(input logic v, input int pos);
		logic [31:0] r;
		r = IMG_RST;
		r[pos] = v;
		return r;
	endfunction

	// Port 0 is the upstream port; only ports 1 and 2 take the downstream-only bits
	for (genvar p = 0; p < PORTS; p++) begin : g_port
		localparam logic DN = (p != 0);
		assign img_74_o[p] = f_74(word_a_i, word_b_i);
		assign img_cc_o[p] = f_cc(word_a_i, word_b_i, DN);
		assign img_8c_o[p] = f_8c(word_b_i);
		assign img_144_o[p] = f_bit(word_a_i[A_VC], D144_VC);
		assign img_3c_o[p] = f_bit(word_a_i[A_INTA] & DN, D3C_INTA);
		assign img_70_o[p] = f_bit(word_b_i[B_PMDIS], D70_PMDIS)
			| f_bit(word_b_i[B_MSIDIS], D70_MSIDIS);
		assign img_c4_o[p] = f_bit(word_b_i[B_RBER], DC4_RBER)
			| {30'h0000_0000, word_b_i[B_MPS +: W_MPS]};
		assign img_e4_o[p] = f_bit(word_b_i[B_LTR], DE4_LTR);
	end
endmodule // cfgld_scatter

// *** cfgld_loader.sv ***
// Configuration word loader: fetches words, checks signature, loads port images
`timescale 1ns/1ns
module cfgld_loader import cfgld_pkg::*; #(
	parameter logic [WORD_W-1:0] SIGNATURE = SIG_DEFAULT
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic load_start_i,
	output logic rom_rd_o,
	output logic [ADDR_W-1:0] rom_addr_o,
	input wire logic [WORD_W-1:0] rom_data_i,
	input wire logic rom_ack_i,
	output logic load_busy_o,
	output logic load_done_o,
	output logic sig_err_o,
	output logic [WORD_W-1:0] id_vendor_o,
	output logic [WORD_W-1:0] id_device_o,
	output cfgld_img_type img_3c_o,
	output cfgld_img_type img_70_o,
	output cfgld_img_type img_74_o,
	output cfgld_img_type img_8c_o,
	output cfgld_img_type img_c4_o,
	output cfgld_img_type img_cc_o,
	output cfgld_img_type img_e4_o,
	output cfgld_img_type img_144_o
);
	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic f_is_rd(input cfgld_state_type s);
		return (s == ST_SIG) || (s == ST_VEN) || (s == ST_DEV)
			|| (s == ST_CAPA) || (s == ST_CAPB);
	endfunction

	function automatic logic [ADDR_W-1:0] f_addr(input cfgld_state_type s);
		case (s)
			ST_VEN: return ADDR_VEN;
			ST_DEV: return ADDR_DEV;
			ST_CAPA: return ADDR_CAPA;
			ST_CAPB: return ADDR_CAPB;
			default: return ADDR_SIG;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	cfgld_state_type state_reg;
	cfgld_state_type state_next;
	logic pend_reg;
	logic req_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [WORD_W-1:0] wa_reg;
	logic [WORD_W-1:0] wb_reg;
	cfgld_img_type sc_3c, sc_70, sc_74, sc_8c, sc_c4, sc_cc, sc_e4, sc_144;

	cfgld_word_if wif ();

	assign wif.req = req_reg;
	assign wif.addr = addr_reg;

	cfgld_fetch u_fetch (
		.sys_clk_i (sys_clk_i),
		.rst_n_i (rst_n_i),
		.ce_i (ce_i),
		.wif (wif),
		.rom_rd_o (rom_rd_o),
		.rom_addr_o (rom_addr_o),
		.rom_data_i (rom_data_i),
		.rom_ack_i (rom_ack_i)
	);

	cfgld_scatter u_scatter (
		.word_a_i (wa_reg),
		.word_b_i (wb_reg),
		.img_3c_o (sc_3c),
		.img_70_o (sc_70),
		.img_74_o (sc_74),
		.img_8c_o (sc_8c),
		.img_c4_o (sc_c4),
		.img_cc_o (sc_cc),
		.img_e4_o (sc_e4),
		.img_144_o (sc_144)
	);

	// ----------------------------------------------------------------
	// Named decode wires
	// ----------------------------------------------------------------
	wire got_w = ce_i && wif.valid;
	wire sig_match_w = (wif.word == SIGNATURE);
	wire leave_idle_w = ce_i && (state_reg == ST_IDLE) && pend_reg;
	wire apply_w = ce_i && (state_reg == ST_APPLY);
	wire sig_bad_w = got_w && (state_reg == ST_SIG) && !sig_match_w;
	wire issue_w = (state_next != state_reg) && f_is_rd(state_next);
	wire ends_w = (state_next == ST_DONE) || (state_next == ST_FAIL);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (pend_reg)
					state_next = ST_SIG;
			end
			ST_SIG: begin
				// A blank or foreign memory leaves every image at its last loaded value
				if (wif.valid)
					state_next = sig_match_w ? ST_VEN : ST_FAIL;
			end
			ST_VEN: begin
				if (wif.valid)
					state_next = ST_DEV;
			end
			ST_DEV: begin
				if (wif.valid)
					state_next = ST_CAPA;
			end
			ST_CAPA: begin
				if (wif.valid)
					state_next = ST_CAPB;
			end
			ST_CAPB: begin
				if (wif.valid)
					state_next = ST_APPLY;
			end
			ST_APPLY: begin
				state_next = ST_DONE;
			end
			ST_DONE, ST_FAIL: begin
				if (pend_reg)
					state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
			req_reg <= 1'b0;
			addr_reg <= ADDR_RST;
		end else if (ce_i) begin
			state_reg <= state_next;
			req_reg <= issue_w;
			addr_reg <= f_addr(state_next);
		end
	end

	// Reload request; a request during a load is kept and served afterwards
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			pend_reg <= 1'b1;
		else if (ce_i && load_start_i)
			pend_reg <= 1'b1;
		else if (leave_idle_w)
			pend_reg <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Word capture
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			id_vendor_o <= WORD_RST;
			id_device_o <= WORD_RST;
			wa_reg <= WORD_RST;
			wb_reg <= WORD_RST;
		end else if (got_w) begin
			if (state_reg == ST_VEN)
				id_vendor_o <= wif.word;
			if (state_reg == ST_DEV)
				id_device_o <= wif.word;
			if (state_reg == ST_CAPA)
				wa_reg <= wif.word;
			if (state_reg == ST_CAPB)
				wb_reg <= wif.word;
		end
	end

	// ----------------------------------------------------------------
	// Status
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			load_busy_o <= 1'b0;
			load_done_o <= 1'b0;
			sig_err_o <= 1'b0;
		end else if (ce_i) begin
			load_busy_o <= !ends_w;
			load_done_o <= apply_w || (load_done_o && !leave_idle_w);
			sig_err_o <= sig_bad_w || (sig_err_o && !leave_idle_w);
		end
	end

	// ----------------------------------------------------------------
	// Register images, written all at once so software never sees a mix
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			img_3c_o <= {PORTS{IMG_RST}};
			img_70_o <= {PORTS{IMG_RST}};
			img_74_o <= {PORTS{IMG_RST}};
			img_8c_o <= {PORTS{IMG_RST}};
			img_c4_o <= {PORTS{IMG_RST}};
			img_cc_o <= {PORTS{IMG_RST}};
			img_e4_o <= {PORTS{IMG_RST}};
			img_144_o <= {PORTS{IMG_RST}};
		end else if (apply_w) begin
			img_3c_o <= sc_3c;
			img_70_o <= sc_70;
			img_74_o <= sc_74;
			img_8c_o <= sc_8c;
			img_c4_o <= sc_c4;
			img_cc_o <= sc_cc;
			img_e4_o <= sc_e4;
			img_144_o <= sc_144;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_last_word;
		(state_reg == ST_CAPB) && got_w;
	endsequence

	sequence s_apply;
		(state_reg == ST_APPLY) && ce_i;
	endsequence

	AST_SIG_GATE: assert property (
		sig_bad_w |=> (state_reg == ST_FAIL) && sig_err_o && !load_done_o
	) else $error("signature mismatch did not stop the load");

	AST_RD_HOLD: assert property (
		rom_rd_o && !(ce_i && rom_ack_i) |=> rom_rd_o && $stable(rom_addr_o)
	) else $error("read request dropped before acknowledge");

	AST_SIG_FIRST: assert property (
		$rose(rom_rd_o) && (state_reg == ST_SIG) |-> rom_addr_o == ADDR_SIG
	) else $error("first read of a load is not the signature word");

	AST_PEND_KEPT: assert property (
		ce_i && load_start_i |=> pend_reg
	) else $error("reload request lost");

	AST_RELOAD_CLEARS: assert property (
		leave_idle_w |=> load_busy_o && !load_done_o && !sig_err_o
	) else $error("status not restarted when a load begins");

	AST_IMG_ONLY_ON_APPLY: assert property (
		!$stable(img_74_o) || !$stable(img_cc_o) |-> $past(apply_w)
	) else $error("images changed outside the apply step");

	AST_LOAD_DONE: assert property (
		s_last_word ##1 s_apply |=> load_done_o && !load_busy_o && !sig_err_o
	) else $error("load did not finish after the last word");

	AST_VC_COUNT: assert property (
		s_apply |=> img_144_o[2][D144_VC] == $past(wa_reg[A_VC])
			&& img_144_o[0][D144_VC] == $past(wa_reg[A_VC])
	) else $error("extended VC count not loaded");

	AST_EXIT_LAT: assert property (
		s_apply |=> img_cc_o[1][DCC_L0S +: W_LAT] == $past(wa_reg[A_L0S +: W_LAT])
			&& img_cc_o[0][DCC_L1 +: W_LAT] == $past(wa_reg[A_L1 +: W_LAT])
	) else $error("exit latency fields not loaded");

	AST_SWITCH_MODE: assert property (
		s_apply |=> img_74_o[2][D74_NOEGR] == $past(wa_reg[A_NOEGR])
			&& img_74_o[0][D74_NOTAG] == $past(wa_reg[A_NOTAG])
			&& img_74_o[1][D74_SAF] == $past(wa_reg[A_SAF])
			&& img_74_o[0][D74_CUT +: W_CUT] == $past(wa_reg[A_CUT +: W_CUT])
			&& img_74_o[2][D74_ARB] == $past(wa_reg[A_ARB])
			&& img_74_o[1][D74_CRD] == $past(wa_reg[A_CRD])
	) else $error("switch mode fields not loaded");

	AST_INTPIN_DOWN: assert property (
		s_apply |=> img_3c_o[1][D3C_INTA] == $past(wa_reg[A_INTA])
			&& img_3c_o[2][D3C_INTA] == $past(wa_reg[A_INTA])
	) else $error("interrupt pin not loaded on a downstream port");

	AST_UPSTREAM_CLEAR: assert property (
		!img_3c_o[0][D3C_INTA] && !img_cc_o[0][DCC_LBN]
	) else $error("downstream-only bit set on the upstream port");

	AST_DEVCAP: assert property (
		s_apply |=> img_c4_o[2][DC4_MPS +: W_MPS] == $past(wb_reg[B_MPS +: W_MPS])
			&& img_c4_o[0][DC4_RBER] == $past(wb_reg[B_RBER])
	) else $error("device capability fields not loaded");

	AST_LINKCAP_B: assert property (
		s_apply |=> img_cc_o[2][DCC_ASPM +: W_ASPM] == $past(wb_reg[B_ASPM +: W_ASPM])
			&& img_cc_o[0][DCC_SDN] == $past(wb_reg[B_SDN])
			&& img_cc_o[1][DCC_LBN] == $past(wb_reg[B_LBN])
	) else $error("link capability fields not loaded");

	AST_CAP_DISABLE: assert property (
		s_apply |=> img_70_o[1][D70_MSIDIS] == $past(wb_reg[B_MSIDIS])
			&& img_70_o[2][D70_PMDIS] == $past(wb_reg[B_PMDIS])
			&& img_74_o[0][D74_CPPDIS] == $past(wb_reg[B_CPPDIS])
	) else $error("capability disables not loaded");

	AST_TL_CTRL: assert property (
		s_apply |=> img_8c_o[0][D8C_PPNP] == $past(wb_reg[B_PPNP])
			&& img_8c_o[1][D8C_ORDFRZ] == $past(wb_reg[B_ORDFRZ])
			&& img_8c_o[2][D8C_TXSOF] == $past(wb_reg[B_TXSOF])
			&& img_8c_o[0][D8C_PMDS] == $past(wb_reg[B_PMDS])
			&& img_8c_o[1][D8C_BND4K] == $past(wb_reg[B_BND4K])
			&& img_e4_o[2][DE4_LTR] == $past(wb_reg[B_LTR])
	) else $error("control fields of the second word not loaded");
endmodule // cfgld_loader

// *** cfgld_rom_model.sv ***
// Behavioural model of the external memory word reader
`timescale 1ns/1ns
module cfgld_rom_model import cfgld_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic rom_rd_i,
	input wire logic [ADDR_W-1:0] rom_addr_i,
	input wire logic [7:0] delay_i,
	output logic [WORD_W-1:0] rom_data_o,
	output logic rom_ack_o
);
	logic [WORD_W-1:0] mem [0:127];
	logic [7:0] wait_reg;
	int reads;
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rom_ack_o <= 1'b0;
			rom_data_o <= 16'hA5A5;
			wait_reg <= 8'h00;
			reads <= 0;
		end else if (rom_ack_o) begin
			// Word is only valid in the ack cycle; scramble it afterwards
			rom_ack_o <= 1'b0;
			rom_data_o <= ~rom_data_o;
		end else if (rom_rd_i && wait_reg >= delay_i) begin
			rom_ack_o <= 1'b1;
			rom_data_o <= mem[rom_addr_i[7:1]];
			reads <= reads + 1;
			wait_reg <= 8'h00;
		end else begin
			rom_data_o <= ~rom_data_o;
			wait_reg <= rom_rd_i ? wait_reg + 8'h01 : 8'h00;
		end
	end
endmodule // cfgld_rom_model

// *** cfgld_loader_tb.sv ***
// Self-checking bench for the configuration word loader
`timescale 1ns/1ns
module cfgld_loader_tb import cfgld_pkg::*;;
	// Arbitrary signature, not tied to any real part
	localparam logic [15:0] SIG_VAL = 16'h5A3C;
	logic sys_clk_i, rst_n_i, ce_i, load_start_i;
	logic rom_rd_o, rom_ack_i, load_busy_o, load_done_o, sig_err_o;
	logic [7:0] rom_addr_o, delay;
	logic [15:0] rom_data_i, id_vendor_o, id_device_o, wa, wb;
	cfgld_img_type img_3c_o, img_70_o, img_74_o, img_8c_o;
	cfgld_img_type img_c4_o, img_cc_o, img_e4_o, img_144_o;
	int miscompares, compares, r0, n;
	cfgld_loader #(.SIGNATURE(SIG_VAL)) dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.ce_i(ce_i), .load_start_i(load_start_i), .rom_rd_o(rom_rd_o),
		.rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i), .rom_ack_i(rom_ack_i),
		.load_busy_o(load_busy_o), .load_done_o(load_done_o), .sig_err_o(sig_err_o),
		.id_vendor_o(id_vendor_o), .id_device_o(id_device_o), .img_3c_o(img_3c_o),
		.img_70_o(img_70_o), .img_74_o(img_74_o), .img_8c_o(img_8c_o),
		.img_c4_o(img_c4_o), .img_cc_o(img_cc_o), .img_e4_o(img_e4_o),
		.img_144_o(img_144_o));
	cfgld_rom_model rom_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .rom_rd_i(rom_rd_o),
		.rom_addr_i(rom_addr_o), .delay_i(delay), .rom_data_o(rom_data_i),
		.rom_ack_o(rom_ack_i));
	always #4 sys_clk_i = ~sys_clk_i;
	// ----------------------------------------------------------------
	// Compare and access tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_imgs(input logic [15:0] a, input logic [15:0] b);
		for (int p = 0; p < 3; p++) begin
			chk(img_144_o[p], 32'(a[0]));
			chk(img_cc_o[p], (32'(a[3:1]) << 12) | (32'(a[6:4]) << 15)
				| (32'(b[3:2]) << 10) | (32'(b[12]) << 19)
				| (32'(b[9] && p > 0) << 21));
			chk(img_74_o[p], (32'(a[8]) << 5) | (32'(a[9]) << 6)
				| 32'(a[10]) | (32'(a[12:11]) << 1)
				| (32'(a[13]) << 3) | (32'(a[14]) << 4)
				| (32'(b[6]) << 15));
			chk(img_3c_o[p], 32'(a[15] && p > 0) << 8);
			chk(img_c4_o[p], 32'(b[1:0]) | (32'(b[4]) << 15));
			chk(img_70_o[p], (32'(b[5]) << 14) | (32'(b[7]) << 13));
			chk(img_8c_o[p], (32'(b[8]) << 5) | (32'(b[10]) << 6)
				| 32'(b[11]) | (32'(b[13]) << 1)
				| (32'(b[15]) << 3));
			chk(img_e4_o[p], 32'(b[14]) << 12);
		end
	endtask
	task automatic start_load(input logic [15:0] sig, a, b, input logic [7:0] dly);
		rom_u.mem[0] = sig;
		rom_u.mem[3] = a;
		rom_u.mem[6] = b;
		delay = dly;
		r0 = rom_u.reads;
		@(negedge sys_clk_i);
		load_start_i = 1'b1;
		@(negedge sys_clk_i);
		load_start_i = 1'b0;
		// Busy only rises one edge after the request is taken
		repeat (2) @(negedge sys_clk_i);
	endtask
	task automatic wait_idle();
		n = 0;
		while (load_busy_o !== 1'b0 && n < 3000) begin
			@(negedge sys_clk_i);
			n++;
		end
		chk_flag(n < 3000, 1'b1);
	endtask
	task automatic print_verdict();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		#(20000 * 8);
		miscompares++;
		$display("watchdog expired");
		print_verdict();
	end
	initial begin
		sys_clk_i = 1'b0;
		rst_n_i = 1'b0;
		ce_i = 1'b1;
		load_start_i = 1'b0;
		delay = 8'h00;
		miscompares = 0;
		compares = 0;
		rom_u.mem[0] = SIG_VAL;
		rom_u.mem[1] = 16'h1234;
		rom_u.mem[2] = 16'h5678;
		rom_u.mem[3] = 16'hA5C3;
		rom_u.mem[6] = 16'h3C5A;
		repeat (20) @(negedge sys_clk_i);
		chk(img_cc_o[1], 32'h0000_0000);
		chk_flag(load_done_o | load_busy_o | rom_rd_o | sig_err_o, 1'b0);
		rst_n_i = 1'b1;
		// Load starts by itself after reset
		repeat (3) @(negedge sys_clk_i);
		wait_idle();
		chk_flag(load_done_o, 1'b1);
		chk(id_vendor_o, 32'h1234);
		chk(id_device_o, 32'h5678);
		chk_imgs(16'hA5C3, 16'h3C5A);
		$display("test reset_autoload done");
		// Walking ones, then all clear, then all set, with varied ack delay
		for (int i = 0; i < 18; i++) begin
			wa = (i < 16) ? (16'h0001 << i) : {16{i == 17}};
			wb = (i < 16) ? (16'h8000 >> i) : {16{i == 17}};
			start_load(SIG_VAL, wa, wb, 8'(i % 5));
			wait_idle();
			chk_flag(load_done_o, 1'b1);
			chk(rom_u.reads - r0, 32'h5);
			chk_imgs(wa, wb);
		end
		$display("test bit_map done");
		// One bit off in the signature: nothing may be loaded
		rom_u.mem[1] = 16'hEEEE;
		start_load(SIG_VAL ^ 16'h0001, 16'h0000, 16'h0000, 8'h02);
		wait_idle();
		chk_flag(sig_err_o, 1'b1);
		chk_flag(load_done_o, 1'b0);
		chk(rom_u.reads - r0, 32'h1);
		chk(id_vendor_o, 32'h1234);
		chk_imgs(16'hFFFF, 16'hFFFF);
		$display("test bad_signature done");
		// Clock enable low mid-load freezes the read request
		start_load(SIG_VAL, 16'h6B29, 16'h94D6, 8'h03);
		repeat (3) @(negedge sys_clk_i);
		ce_i = 1'b0;
		// Signature read is outstanding here and must stay so while frozen
		chk_flag(rom_rd_o, 1'b1);
		repeat (12) @(negedge sys_clk_i);
		chk_flag(rom_rd_o, 1'b1);
		chk(rom_addr_o, 32'h0000_0000);
		chk_flag(load_busy_o, 1'b1);
		ce_i = 1'b1;
		wait_idle();
		chk_flag(sig_err_o, 1'b0);
		chk(id_vendor_o, 32'hEEEE);
		chk_imgs(16'h6B29, 16'h94D6);
		$display("test clock_enable done");
		print_verdict();
	end
endmodule // cfgld_loader_tb
